/* File: common/asx_pkg.sv */
// Shared constants and types for the subtract / XOR / swap datapath.
// Assumes a single AHB-Lite master and one 100 MHz core clock.
package asx_pkg;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [11:0] ACC_OFFSET = 12'h000; // Accumulator
	localparam logic [11:0] STATUS_OFFSET = 12'h004; // Flags
	localparam logic [11:0] CMD_OFFSET = 12'h008; // Execute command (write)
	localparam logic [11:0] DIR_OFFSET = 12'h00c; // Port direction bytes
	localparam logic [11:0] FILE_BASE = 12'h200; // File registers, one word each
	localparam int FILE_DEPTH = 128; // File addresses 0 to 127

	// ********************************
	// Command word field positions
	// ********************************
	localparam int CMD_OP_LSB = 0; // Operation code, 3 bits
	localparam int CMD_DEST_BIT = 3; // 0 accumulator, 1 file register
	localparam int CMD_DEST_GIVEN_BIT = 4; // 0 means destination omitted
	localparam int CMD_ADDR_LSB = 8; // File address, 7 bits
	localparam int CMD_LIT_LSB = 16; // Literal, 8 bits

	// ********************************
	// Direction register layout and resets
	// ********************************
	localparam int DIR_A_LSB = 0;
	localparam int DIR_B_LSB = 8;
	localparam int DIR_C_LSB = 16;
	localparam logic [7:0] DIR_RESET = 8'hff; // All pins input
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [6:0] DIR_SEL_A = 7'h05;
	localparam logic [6:0] DIR_SEL_B = 7'h06;
	localparam logic [6:0] DIR_SEL_C = 7'h07;

	// Operation codes carried in the command word
	typedef enum logic [2:0] {
		OP_NONE,
		OP_SUB_ACC_FROM_FILE,
		OP_SUB_WITH_BORROW,
		OP_NIBBLE_EXCHANGE,
		OP_LOAD_DIRECTION_REG,
		OP_EXCLUSIVE_OR_LITERAL,
		OP_EXCLUSIVE_OR_FILE
	} asx_op_e;

	// Status flags, bit 0 carry, bit 1 half borrow, bit 2 zero
	typedef struct packed {
		logic resultNull;
		logic halfBorrow;
		logic borrowInverse;
	} asx_flags_s;

	localparam asx_flags_s FLAGS_RESET = '{default: 1'b0};

endpackage

/* File: hdl/asx_core.sv */
// Datapath for subtract, subtract with borrow, nibble exchange, direction
// load and exclusive-or, with its registers on an AHB-Lite slave port.
// Assumes one AHB-Lite master, single word transfers, hready looped back.
`timescale 1ns/10ps

// Overview of operation
// - Subtract from file sets carry, half borrow, zero
// - Borrow subtract updates carry, half, zero
// - Borrow subtract order: accumulator minus file
// - Destination bit zero accumulator, one file
// - Nibble exchange swaps halves, flags untouched
// - Omitted exchange destination means file register
// - Direction load: operands five to seven only
// - Literal XOR into accumulator, zero only
// - File XOR routed by destination, zero only
module asx_core (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [7:0] portADirection,
	output logic [7:0] portBDirection,
	output logic [7:0] portCDirection
);

	// ********************************
	// Bus slave state
	// ********************************
	typedef enum {ST_IDLE, ST_WRITE, ST_READ, ST_READOUT} asx_bus_e;
	asx_bus_e busState_reg; // Phase of the current transfer
	asx_bus_e busState_next;
	logic [11:0] addr_reg; // Latched address phase
	logic [31:0] hrdata_reg; // Read data, loaded in wait cycle

	// ********************************
	// Datapath state
	// ********************************
	logic [7:0] acc_reg; // Accumulator
	asx_pkg::asx_flags_s flags_reg; // Carry, half borrow, zero
	logic [7:0] dirA_reg; // Port A direction
	logic [7:0] dirB_reg; // Port B direction
	logic [7:0] dirC_reg; // Port C direction
	logic [7:0] fileMem [asx_pkg::FILE_DEPTH]; // File register array

	// ********************************
	// Address phase decode
	// ********************************
	wire addrTaken = hsel && htrans[1] && hready; // Request accepted
	wire inDataWrite = (busState_reg == ST_WRITE); // Write data phase
	wire hitAcc = (addr_reg == asx_pkg::ACC_OFFSET);
	wire hitStatus = (addr_reg == asx_pkg::STATUS_OFFSET);
	wire hitCmd = (addr_reg == asx_pkg::CMD_OFFSET);
	wire hitDir = (addr_reg == asx_pkg::DIR_OFFSET);
	wire hitFile = (addr_reg[11:9] == asx_pkg::FILE_BASE[11:9]) && (addr_reg[1:0] == 2'b00);
	wire [6:0] busFileAddr = addr_reg[8:2];

	// Next bus state from the current phase and a new request
	always_comb begin
		busState_next = busState_reg;
		case (busState_reg)
			ST_READ: begin
				busState_next = ST_READOUT;
			end
			default: begin
				if (addrTaken) begin
					busState_next = hwrite ? ST_WRITE : ST_READ;
				end else begin
					busState_next = ST_IDLE;
				end
			end
		endcase
	end

	// One wait state on reads so read data comes from a flip-flop
	assign hreadyout = (busState_reg != ST_READ);
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// ********************************
	// Command decode
	// ********************************
	wire execValid = inDataWrite && hitCmd; // Command write executes now
	wire [2:0] cmdOpBits = hwdata[asx_pkg::CMD_OP_LSB +: 3];
	wire asx_pkg::asx_op_e cmdOp = asx_pkg::asx_op_e'(cmdOpBits);
	wire cmdDestBit = hwdata[asx_pkg::CMD_DEST_BIT];
	wire cmdDestGiven = hwdata[asx_pkg::CMD_DEST_GIVEN_BIT];
	wire [6:0] cmdAddr = hwdata[asx_pkg::CMD_ADDR_LSB +: 7];
	wire [7:0] cmdLit = hwdata[asx_pkg::CMD_LIT_LSB +: 8];
	wire [7:0] fileOperand = fileMem[cmdAddr];

	// ********************************
	// Shared subtracter: a + ~b + cin
	// ********************************
	wire isSubFile = (cmdOp == asx_pkg::OP_SUB_ACC_FROM_FILE);
	wire isSubBorrow = (cmdOp == asx_pkg::OP_SUB_WITH_BORROW);
	// File minus accumulator, or accumulator minus file minus borrow
	wire [7:0] subA = isSubFile ? fileOperand : acc_reg;
	wire [7:0] subB = isSubFile ? acc_reg : fileOperand;
	wire subCin = isSubFile ? 1'b1 : flags_reg.borrowInverse;
	wire [8:0] subSum = {1'b0, subA} + {1'b0, ~subB} + {8'h00, subCin};
	wire [4:0] subNib = {1'b0, subA[3:0]} + {1'b0, ~subB[3:0]} + {4'h0, subCin};
	// Carry out is one when no borrow happened
	wire subCarry = subSum[8];
	wire subHalf = subNib[4];

	// ********************************
	// Result select and destination
	// ********************************
	wire [7:0] swapResult = {fileOperand[3:0], fileOperand[7:4]};
	wire [7:0] xorLitResult = acc_reg ^ cmdLit;
	wire [7:0] xorFileResult = acc_reg ^ fileOperand;
	wire [7:0] opResult = (isSubFile || isSubBorrow) ? subSum[7:0] :
		(cmdOp == asx_pkg::OP_NIBBLE_EXCHANGE) ? swapResult :
		(cmdOp == asx_pkg::OP_EXCLUSIVE_OR_LITERAL) ? xorLitResult : xorFileResult;
	wire resultZero = (opResult == 8'h00);
	wire writesResult = isSubFile || isSubBorrow ||
		(cmdOp == asx_pkg::OP_NIBBLE_EXCHANGE) ||
		(cmdOp == asx_pkg::OP_EXCLUSIVE_OR_LITERAL) ||
		(cmdOp == asx_pkg::OP_EXCLUSIVE_OR_FILE);
	// Omitted destination on exchange defaults to file register
	wire swapDefault = (cmdOp == asx_pkg::OP_NIBBLE_EXCHANGE) && !cmdDestGiven;
	wire destFile = (cmdOp != asx_pkg::OP_EXCLUSIVE_OR_LITERAL) &&
		(cmdDestBit || swapDefault);
	wire execToAcc = execValid && writesResult && !destFile;
	wire execToFile = execValid && writesResult && destFile;
	wire isLoadDir = execValid && (cmdOp == asx_pkg::OP_LOAD_DIRECTION_REG);
	wire setsAllFlags = execValid && (isSubFile || isSubBorrow);
	wire setsZeroOnly = execValid && ((cmdOp == asx_pkg::OP_EXCLUSIVE_OR_LITERAL) ||
		(cmdOp == asx_pkg::OP_EXCLUSIVE_OR_FILE));

	// Bus writes to plain registers
	wire busAccWr = inDataWrite && hitAcc;
	wire busStatusWr = inDataWrite && hitStatus;
	wire busDirWr = inDataWrite && hitDir;
	wire busFileWr = inDataWrite && hitFile;

	// Read multiplexer, unmapped addresses read zero
	wire [31:0] readValue = hitAcc ? {24'h000000, acc_reg} :
		hitStatus ? {29'h00000000, flags_reg} :
		hitDir ? {8'h00, dirC_reg, dirB_reg, dirA_reg} :
		hitFile ? {24'h000000, fileMem[busFileAddr]} : 32'h00000000;

	// ********************************
	// Bus phase registers
	// ********************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busState_reg <= ST_IDLE;
			addr_reg <= 12'h000;
		end else begin
			busState_reg <= busState_next;
			if (addrTaken && hreadyout) begin
				addr_reg <= haddr;
			end
		end
	end

	// Read data captured during the wait cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata_reg <= 32'h00000000;
		end else if (busState_reg == ST_READ) begin
			hrdata_reg <= readValue;
		end
	end

	// ********************************
	// Accumulator and flags
	// ********************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_reg <= asx_pkg::ACC_RESET;
		end else if (execToAcc) begin
			acc_reg <= opResult;
		end else if (busAccWr) begin
			acc_reg <= hwdata[7:0];
		end
	end

	// Flags change only for the operations that affect them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_reg <= asx_pkg::FLAGS_RESET;
		end else if (setsAllFlags) begin
			flags_reg <= '{resultNull: resultZero, halfBorrow: subHalf,
				borrowInverse: subCarry};
		end else if (setsZeroOnly) begin
			flags_reg.resultNull <= resultZero;
		end else if (busStatusWr) begin
			flags_reg <= asx_flags_from(hwdata[2:0]);
		end
	end

	// Status word to flags
	function automatic asx_pkg::asx_flags_s asx_flags_from(input logic [2:0] bits);
		return asx_pkg::asx_flags_s'(bits);
	endfunction

	// ********************************
	// Direction registers
	// ********************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dirA_reg <= asx_pkg::DIR_RESET;
			dirB_reg <= asx_pkg::DIR_RESET;
			dirC_reg <= asx_pkg::DIR_RESET;
		end else if (isLoadDir) begin
			// Operands outside five to seven load nothing
			if (cmdAddr == asx_pkg::DIR_SEL_A) begin
				dirA_reg <= acc_reg;
			end else if (cmdAddr == asx_pkg::DIR_SEL_B) begin
				dirB_reg <= acc_reg;
			end else if (cmdAddr == asx_pkg::DIR_SEL_C) begin
				dirC_reg <= acc_reg;
			end
		end else if (busDirWr) begin
			dirA_reg <= hwdata[asx_pkg::DIR_A_LSB +: 8];
			dirB_reg <= hwdata[asx_pkg::DIR_B_LSB +: 8];
			dirC_reg <= hwdata[asx_pkg::DIR_C_LSB +: 8];
		end
	end

	assign portADirection = dirA_reg;
	assign portBDirection = dirB_reg;
	assign portCDirection = dirC_reg;

	// ********************************
	// File register array, no reset
	// ********************************
	always_ff @(posedge clk) begin
		if (execToFile) begin
			fileMem[cmdAddr] <= opResult;
		end else if (busFileWr) begin
			fileMem[busFileAddr] <= hwdata[7:0];
		end
	end

	// ********************************
	// Checks
	// ********************************
	a_sub_file_carry: assert property (@(posedge clk) disable iff (!reset_n)
		(execValid && isSubFile) |=> flags_reg.borrowInverse ==
			($past(acc_reg) <= $past(fileOperand)) &&
		flags_reg.halfBorrow == ($past(acc_reg[3:0]) <= $past(fileOperand[3:0])))
		else $error("Subtract from file flags wrong");

	a_borrow_sub_value: assert property (@(posedge clk) disable iff (!reset_n)
		(execToAcc && isSubBorrow) |=> acc_reg == 8'($past(acc_reg) - $past(fileOperand)
			- {7'h00, !$past(flags_reg.borrowInverse)}))
		else $error("Borrow subtract result wrong");

	a_borrow_sub_carry: assert property (@(posedge clk) disable iff (!reset_n)
		(execValid && isSubBorrow) |=> flags_reg.borrowInverse == ({1'b0, $past(acc_reg)} >=
			({1'b0, $past(fileOperand)} + {8'h00, !$past(flags_reg.borrowInverse)})))
		else $error("Borrow subtract carry wrong");

	// Literal exclusive-or has no destination bit and always lands in the accumulator
	a_dest_to_file: assert property (@(posedge clk) disable iff (!reset_n)
		(execValid && writesResult && cmdDestBit && !busAccWr &&
			cmdOp != asx_pkg::OP_EXCLUSIVE_OR_LITERAL) |=> $stable(acc_reg))
		else $error("File destination changed accumulator");

	// Swapped byte must appear in whichever destination the command fields select
	a_swap_nibbles: assert property (@(posedge clk) disable iff (!reset_n)
		(execValid && cmdOp == asx_pkg::OP_NIBBLE_EXCHANGE) |=> $stable(flags_reg) &&
		((($past(cmdDestGiven) && !$past(cmdDestBit)) ? acc_reg : fileMem[$past(cmdAddr)]) ==
			{$past(fileOperand[3:0]), $past(fileOperand[7:4])}))
		else $error("Nibble exchange wrong");

	a_swap_default: assert property (@(posedge clk) disable iff (!reset_n)
		(execValid && cmdOp == asx_pkg::OP_NIBBLE_EXCHANGE && !cmdDestGiven) |=>
		$stable(acc_reg) && fileMem[$past(cmdAddr)] ==
			{$past(fileOperand[3:0]), $past(fileOperand[7:4])})
		else $error("Omitted destination went to accumulator");

	a_dir_load: assert property (@(posedge clk) disable iff (!reset_n)
		(isLoadDir && cmdAddr == asx_pkg::DIR_SEL_B) |=> portBDirection == $past(acc_reg) &&
		$stable(portADirection) && $stable(portCDirection) && $stable(flags_reg))
		else $error("Direction load wrong");

	a_xor_literal: assert property (@(posedge clk) disable iff (!reset_n)
		(execValid && cmdOp == asx_pkg::OP_EXCLUSIVE_OR_LITERAL) |=>
		acc_reg == ($past(acc_reg) ^ $past(cmdLit)) &&
		flags_reg.borrowInverse == $past(flags_reg.borrowInverse) &&
		flags_reg.halfBorrow == $past(flags_reg.halfBorrow))
		else $error("Literal exclusive-or wrong");

	a_zero_flag: assert property (@(posedge clk) disable iff (!reset_n)
		(execValid && cmdOp == asx_pkg::OP_EXCLUSIVE_OR_FILE) |=>
		flags_reg.resultNull == ($past(acc_reg) == $past(fileOperand)))
		else $error("Zero flag wrong after file exclusive-or");

	a_read_wait: assert property (@(posedge clk) disable iff (!reset_n)
		(addrTaken && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
		else $error("Read wait state missing");

endmodule // asx_core

/* File: tb/asx_core_bench.sv */
// Self-checking bench for the subtract / XOR / swap datapath.
// Assumes the bench is the only AHB-Lite master, with hready looped back.
`timescale 1ns/10ps
module asx_core_bench;
	// Row: preset state, command fields, expected state
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] fv;
		logic [2:0] st;
		logic [2:0] op;
		logic dst;
		logic gvn;
		logic [6:0] adr;
		logic [7:0] lit;
		logic [7:0] eAcc;
		logic [7:0] eF;
		logic [2:0] eSt;
	} asx_row_s;
	// ********************************
	// Signals and design
	// ********************************
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2; // Whole words only
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [7:0] dirA;
	logic [7:0] dirB;
	logic [7:0] dirC;
	logic [31:0] rd; // Last read word
	logic [7:0] eA; // Expected direction bytes
	logic [7:0] eB;
	logic [7:0] eC;
	int err_total = 0;
	int cmp_count = 0;
	asx_row_s rows [15] = '{
		'{8'h05, 8'h05, 3'h0, 3'h1, 1'b0, 1'b1, 7'h10, 8'h00, 8'h00, 8'h05, 3'h7},
		'{8'h06, 8'h05, 3'h7, 3'h1, 1'b1, 1'b1, 7'h7f, 8'h00, 8'h06, 8'hff, 3'h0},
		'{8'h18, 8'h21, 3'h2, 3'h1, 1'b0, 1'b1, 7'h00, 8'h00, 8'h09, 8'h21, 3'h1},
		'{8'h30, 8'h10, 3'h1, 3'h2, 1'b0, 1'b1, 7'h01, 8'h00, 8'h20, 8'h10, 3'h3},
		'{8'h10, 8'h10, 3'h0, 3'h2, 1'b1, 1'b1, 7'h02, 8'h00, 8'h10, 8'hff, 3'h0},
		'{8'h10, 8'h0f, 3'h0, 3'h2, 1'b0, 1'b1, 7'h03, 8'h00, 8'h00, 8'h0f, 3'h5},
		'{8'h3c, 8'ha5, 3'h7, 3'h3, 1'b0, 1'b1, 7'h04, 8'h00, 8'h5a, 8'ha5, 3'h7},
		'{8'h00, 8'h12, 3'h2, 3'h3, 1'b0, 1'b0, 7'h05, 8'h00, 8'h00, 8'h21, 3'h2},
		'{8'h11, 8'hf0, 3'h5, 3'h3, 1'b1, 1'b1, 7'h06, 8'h00, 8'h11, 8'h0f, 3'h5},
		'{8'h5a, 8'h77, 3'h3, 3'h5, 1'b1, 1'b1, 7'h10, 8'h5a, 8'h00, 8'h77, 3'h7},
		'{8'h0f, 8'h77, 3'h4, 3'h5, 1'b0, 1'b1, 7'h10, 8'hf0, 8'hff, 8'h77, 3'h0},
		'{8'h33, 8'h33, 3'h3, 3'h6, 1'b1, 1'b1, 7'h20, 8'h00, 8'h33, 8'h00, 3'h7},
		'{8'h80, 8'h01, 3'h7, 3'h6, 1'b0, 1'b1, 7'h21, 8'h00, 8'h81, 8'h01, 3'h3},
		'{8'h42, 8'h24, 3'h5, 3'h0, 1'b1, 1'b1, 7'h22, 8'h00, 8'h42, 8'h24, 3'h5},
		'{8'h42, 8'h24, 3'h5, 3'h7, 1'b1, 1'b1, 7'h22, 8'h00, 8'h42, 8'h24, 3'h5}};

	asx_core dut_u (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .portADirection(dirA),
		.portBDirection(dirB), .portCDirection(dirC));

	// Free-running 100 MHz clock
	always #5 clk = ~clk;
	// ********************************
	// Tasks
	// ********************************
	// Verdict and end of run
	task tally_and_finish;
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Compare and report
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Bounded wait for ready; ready is a register, so the low phase shows the edge value
	task automatic waitReady;
		int n;
		n = 0;
		@(negedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				err_total++;
				tally_and_finish();
			end
			@(negedge clk);
		end
		rd = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
		@(posedge clk);
	endtask
	// One single-word transfer: address phase, then data phase
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
	endtask
	// Read and compare
	task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(nm, rd, exp);
	endtask
	// Reset state of ports and registers
	task automatic checkReset;
		check("dirs", {8'h0, dirC, dirB, dirA}, 32'h00ffffff);
		rdChk("acc rst", asx_pkg::ACC_OFFSET, 32'h0);
		rdChk("status rst", asx_pkg::STATUS_OFFSET, 32'h0);
		rdChk("dir rst", asx_pkg::DIR_OFFSET, 32'h00ffffff);
	endtask
	function automatic logic [31:0] mkCmd(input logic [2:0] op, input logic dst, input logic gvn,
		input logic [6:0] adr, input logic [7:0] lit);
		return {8'h00, lit, 1'b0, adr, 3'h0, gvn, dst, op};
	endfunction
	function automatic logic [11:0] fAdr(input logic [6:0] adr);
		return asx_pkg::FILE_BASE + {3'h0, adr, 2'h0};
	endfunction
	// ********************************
	// Main sequence
	// ********************************
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		checkReset();
		// Table of ordinary operations
		foreach (rows[i]) begin
			xfer(1'b1, asx_pkg::ACC_OFFSET, {24'h0, rows[i].acc});
			xfer(1'b1, fAdr(rows[i].adr), {24'h0, rows[i].fv});
			xfer(1'b1, asx_pkg::STATUS_OFFSET, {29'h0, rows[i].st});
			xfer(1'b1, asx_pkg::CMD_OFFSET, mkCmd(rows[i].op, rows[i].dst, rows[i].gvn,
				rows[i].adr, rows[i].lit));
			rdChk($sformatf("acc %0d", i), asx_pkg::ACC_OFFSET, {24'h0, rows[i].eAcc});
			rdChk($sformatf("file %0d", i), fAdr(rows[i].adr), {24'h0, rows[i].eF});
			rdChk($sformatf("st %0d", i), asx_pkg::STATUS_OFFSET, {29'h0, rows[i].eSt});
		end
		// Chained literal XORs: second sees first result
		xfer(1'b1, asx_pkg::ACC_OFFSET, 32'h0f);
		xfer(1'b1, asx_pkg::STATUS_OFFSET, 32'h0);
		xfer(1'b1, asx_pkg::CMD_OFFSET, mkCmd(3'h5, 1'b0, 1'b1, 7'h0, 8'hff));
		xfer(1'b1, asx_pkg::CMD_OFFSET, mkCmd(3'h5, 1'b0, 1'b1, 7'h0, 8'hf0));
		rdChk("xor chain", asx_pkg::ACC_OFFSET, 32'h0);
		rdChk("xor zero", asx_pkg::STATUS_OFFSET, 32'h4);
		// Direction loads, selects four to eight
		eA = 8'hff;
		eB = 8'hff;
		eC = 8'hff;
		for (logic [6:0] s = 7'h04; s <= 7'h08; s++) begin
			xfer(1'b1, asx_pkg::ACC_OFFSET, {24'h0, s[3:0], 4'ha});
			xfer(1'b1, asx_pkg::STATUS_OFFSET, 32'h5);
			xfer(1'b1, asx_pkg::CMD_OFFSET, mkCmd(3'h4, 1'b0, 1'b1, s, 8'h00));
			eA = (s == asx_pkg::DIR_SEL_A) ? {s[3:0], 4'ha} : eA;
			eB = (s == asx_pkg::DIR_SEL_B) ? {s[3:0], 4'ha} : eB;
			eC = (s == asx_pkg::DIR_SEL_C) ? {s[3:0], 4'ha} : eC;
			// Ports settle after the edge that executed the command
			@(negedge clk);
			check("dir ports", {8'h0, dirC, dirB, dirA}, {8'h0, eC, eB, eA});
			rdChk("dir reg", asx_pkg::DIR_OFFSET, {8'h0, eC, eB, eA});
			rdChk("dir flags", asx_pkg::STATUS_OFFSET, 32'h5);
		end
		// Unmapped place: write ignored, reads zero
		xfer(1'b1, 12'h100, 32'hffffffff);
		rdChk("unmapped", 12'h100, 32'h0);
		// Second reset in mid-run
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		checkReset();
		tally_and_finish();
	end
endmodule // asx_core_bench
